// *** ueef_axil_slave.sv ***
`timescale 1ns/100ps
`default_nettype none

module ueef_axil_slave
    import ueef_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic [ADDR_W-1:0] awaddr_i,
    input  wire logic              awvalid_i,
    output var  logic              awready_o,
    input  wire logic [31:0]       wdata_i,
    input  wire logic [3:0]        wstrb_i,
    input  wire logic              wvalid_i,
    output var  logic              wready_o,
    output var  logic [1:0]        bresp_o,
    output var  logic              bvalid_o,
    input  wire logic              bready_i,
    input  wire logic [ADDR_W-1:0] araddr_i,
    input  wire logic              arvalid_i,
    output var  logic              arready_o,
    output var  logic [31:0]       rdata_o,
    output var  logic [1:0]        rresp_o,
    output var  logic              rvalid_o,
    input  wire logic              rready_i,
    output var  ueef_reg_req_s     req_o,
    input  wire ueef_reg_rsp_s     rsp_i
);

    logic [ADDR_W-1:0] awaddr_reg;
    logic [ADDR_W-1:0] araddr_reg;
    logic [31:0]       wdata_reg;
    logic [3:0]        wstrb_reg;
    logic              wr_go;
    logic              rd_go;

    // Both halves held and no response pending
    assign wr_go = !awready_o && !wready_o && !bvalid_o;
    assign rd_go = !arready_o && !rvalid_o;

    always_comb begin
        req_o       = '0;
        req_o.wr    = wr_go;
        req_o.rd    = rd_go;
        req_o.waddr = awaddr_reg;
        req_o.raddr = araddr_reg;
        req_o.wdata = wdata_reg;
        req_o.wstrb = wstrb_reg;
    end

    // Write address and data taken in either order
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            awready_o  <= 1'b1;
            wready_o   <= 1'b1;
            awaddr_reg <= '0;
            wdata_reg  <= '0;
            wstrb_reg  <= '0;
        end else begin
            if (awvalid_i && awready_o) begin
                awready_o  <= 1'b0;
                awaddr_reg <= awaddr_i;
            end else if (bvalid_o && bready_i) begin
                awready_o <= 1'b1;
            end
            if (wvalid_i && wready_o) begin
                wready_o  <= 1'b0;
                wdata_reg <= wdata_i;
                wstrb_reg <= wstrb_i;
            end else if (bvalid_o && bready_i) begin
                wready_o <= 1'b1;
            end
        end
    end

    // Write response
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bvalid_o <= 1'b0;
            bresp_o  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_o <= 1'b1;
            bresp_o  <= rsp_i.werr ? RESP_SLVERR : RESP_OKAY;
        end else if (bready_i) begin
            bvalid_o <= 1'b0;
        end
    end

    // Read address and data
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            arready_o  <= 1'b1;
            araddr_reg <= '0;
            rvalid_o   <= 1'b0;
            rdata_o    <= '0;
            rresp_o    <= RESP_OKAY;
        end else begin
            if (arvalid_i && arready_o) begin
                arready_o  <= 1'b0;
                araddr_reg <= araddr_i;
            end else if (rvalid_o && rready_i) begin
                arready_o <= 1'b1;
            end
            if (rd_go) begin
                rvalid_o <= 1'b1;
                rdata_o  <= rsp_i.rdata;
                rresp_o  <= rsp_i.rerr ? RESP_SLVERR : RESP_OKAY;
            end else if (rready_i) begin
                rvalid_o <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// *** ueef_core.sv ***
// Operation
// RQ1: Tx underflow sets per-endpoint underrun flag
// RQ2: Tx status read clears underrun flag
// RQ3: Completed IN transaction sets done flag
// RQ4: Tx status read clears done flag
// RQ5: Unmasked tx flag drives tx summary
// RQ6: Rx overrun sets per-endpoint overrun flag
// RQ7: Rx event read clears overrun flags
// RQ8: Rx error or last sets complete flag
// RQ9: Rx status read clears complete flag
// RQ10: Freeze suspends every clear on read
// RQ11: Errored endpoint zero packets are discarded
// RQ12: Streaming software must check rx error flags
// RQ13: Reserved bits read zero, writes ignored
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module ueef_core
    import ueef_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic              s_axi_awvalid_i,
    output var  logic              s_axi_awready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output var  logic              s_axi_wready_o,
    output var  logic [1:0]        s_axi_bresp_o,
    output var  logic              s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic              s_axi_arvalid_i,
    output var  logic              s_axi_arready_o,
    output var  logic [31:0]       s_axi_rdata_o,
    output var  logic [1:0]        s_axi_rresp_o,
    output var  logic              s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    input  wire logic              freeze_i,
    input  wire logic [EP_N-1:0]   tx_underrun_set_i,
    input  wire logic [EP_N-1:0]   tx_done_set_i,
    input  wire logic [EP_N-1:0]   tx_status_rd_i,
    input  wire logic [EP_N-1:0]   rx_overrun_set_i,
    input  wire logic [EP_N-1:0]   rx_err_i,
    input  wire logic [EP_N-1:0]   rx_last_i,
    input  wire logic [EP_N-1:0]   rx_status_rd_i,
    input  wire logic              ep0_rx_end_i,
    input  wire logic              ep0_rx_err_i,
    output var  logic              ep0_discard_o,
    output var  logic              ep0_accept_o,
    output var  logic              transmit_summary_event_o,
    output var  logic [EP_N-1:0]   tx_underrun_flags_o,
    output var  logic [EP_N-1:0]   tx_done_flags_o,
    output var  logic [EP_N-1:0]   rx_overrun_flags_o,
    output var  logic [EP_N-1:0]   rx_complete_flags_o,
    output var  logic              irq_o
);

    ueef_reg_req_s    req;
    ueef_reg_rsp_s    rsp;
    logic [6:0]       txmsk_reg;
    logic [IRQ_W-1:0] imsk_reg;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] ist_set;
    logic [IRQ_W-1:0] ist_clr;
    logic [EP_N-1:0]  rx_err_reg;
    logic [EP_N-1:0]  rx_last_reg;
    logic [EP_N-1:0]  rxc_set;
    logic [EP_N-1:0]  tx_clr;
    logic [EP_N-1:0]  rxo_clr;
    logic [EP_N-1:0]  rxc_clr;
    logic [15:0]      txev;
    logic [15:0]      rxev;
    logic             sum_next;
    logic             rd_rxev;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [31:0] idx);
        hit = (a[ADDR_W-1:2] == idx[ADDR_W-3:0]);
    endfunction

    ueef_axil_slave u_bus (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .awaddr_i  (s_axi_awaddr_i),
        .awvalid_i (s_axi_awvalid_i),
        .awready_o (s_axi_awready_o),
        .wdata_i   (s_axi_wdata_i),
        .wstrb_i   (s_axi_wstrb_i),
        .wvalid_i  (s_axi_wvalid_i),
        .wready_o  (s_axi_wready_o),
        .bresp_o   (s_axi_bresp_o),
        .bvalid_o  (s_axi_bvalid_o),
        .bready_i  (s_axi_bready_i),
        .araddr_i  (s_axi_araddr_i),
        .arvalid_i (s_axi_arvalid_i),
        .arready_o (s_axi_arready_o),
        .rdata_o   (s_axi_rdata_o),
        .rresp_o   (s_axi_rresp_o),
        .rvalid_o  (s_axi_rvalid_o),
        .rready_i  (s_axi_rready_i),
        .req_o     (req),
        .rsp_i     (rsp)
    );

    // Clear-on-read strobes, all held off by freeze
    assign rd_rxev = req.rd && hit(req.raddr, RXEV_IDX);
    assign tx_clr  = freeze_i ? '0 : tx_status_rd_i;                 // RQ2 RQ4 RQ10
    assign rxo_clr = (rd_rxev && !freeze_i) ? '1 : '0;               // RQ7 RQ10
    assign rxc_clr = freeze_i ? '0 : rx_status_rd_i;                 // RQ9 RQ10

    // Error or last flag becoming one
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_err_reg  <= FLAG_RST;
            rx_last_reg <= FLAG_RST;
        end else begin
            rx_err_reg  <= rx_err_i;
            rx_last_reg <= rx_last_i;
        end
    end

    assign rxc_set = (rx_err_i & ~rx_err_reg) | (rx_last_i & ~rx_last_reg);   // RQ8

    ueef_flag_bank #(.W(EP_N)) u_txu (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .set_i   (tx_underrun_set_i),                                // RQ1
        .clr_i   (tx_clr),
        .flags_o (tx_underrun_flags_o)
    );

    ueef_flag_bank #(.W(EP_N)) u_txd (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .set_i   (tx_done_set_i),                                    // RQ3
        .clr_i   (tx_clr),
        .flags_o (tx_done_flags_o)
    );

    ueef_flag_bank #(.W(EP_N)) u_rxo (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .set_i   (rx_overrun_set_i),                                 // RQ6
        .clr_i   (rxo_clr),
        .flags_o (rx_overrun_flags_o)
    );

    ueef_flag_bank #(.W(EP_N)) u_rxc (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .set_i   (rxc_set),
        .clr_i   (rxc_clr),
        .flags_o (rx_complete_flags_o)
    );

    // Event register images, reserved bits zero
    always_comb begin
        txev = '0;
        rxev = '0;
        txev[HI_LSB +: EP_N] = tx_underrun_flags_o;                  // RQ13
        txev[LO_LSB +: EP_N] = tx_done_flags_o;
        rxev[HI_LSB +: EP_N] = rx_overrun_flags_o;
        rxev[LO_LSB +: EP_N] = rx_complete_flags_o;
    end

    // Transmit mask, reserved bit dropped
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            txmsk_reg <= TXMSK_RST;
        end else if (req.wr && req.wstrb[0] && hit(req.waddr, TXMSK_IDX)) begin
            txmsk_reg <= req.wdata[6:0] & 7'h77;                     // RQ13
        end
    end

    // Transmit summary
    assign sum_next = |(txev[6:0] & txmsk_reg);                      // RQ5

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            transmit_summary_event_o <= 1'b0;
        end else begin
            transmit_summary_event_o <= sum_next;                    // RQ5
        end
    end

    // Endpoint zero packet verdict
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ep0_discard_o <= 1'b0;
            ep0_accept_o  <= 1'b0;
        end else begin
            ep0_discard_o <= ep0_rx_end_i && ep0_rx_err_i;           // RQ11
            ep0_accept_o  <= ep0_rx_end_i && !ep0_rx_err_i;          // RQ11
        end
    end

    // Interrupt status, mask and output
    always_comb begin
        ist_set               = '0;
        ist_set[IRQ_TX_SUM]   = sum_next && !transmit_summary_event_o;
        ist_set[IRQ_RX_OVR]   = |rx_overrun_set_i;
        ist_set[IRQ_EP0_DISC] = ep0_rx_end_i && ep0_rx_err_i;
        ist_clr               = '0;
        if (req.wr && req.wstrb[0] && hit(req.waddr, IST_IDX)) begin
            ist_clr = req.wdata[IRQ_W-1:0];
        end
    end

    ueef_flag_bank #(.W(IRQ_W)) u_ist (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .set_i   (ist_set),
        .clr_i   (ist_clr),
        .flags_o (ist)
    );

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            imsk_reg <= IMSK_RST;
        end else if (req.wr && req.wstrb[0] && hit(req.waddr, IMSK_IDX)) begin
            imsk_reg <= req.wdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(ist & imsk_reg);
        end
    end

    // Read mux and decode errors
    always_comb begin
        rsp      = '0;
        rsp.rerr = 1'b0;
        if (hit(req.raddr, TXEV_IDX)) begin
            rsp.rdata[15:0] = txev;
        end else if (hit(req.raddr, TXMSK_IDX)) begin
            rsp.rdata[6:0] = txmsk_reg;
        end else if (hit(req.raddr, RXEV_IDX)) begin
            rsp.rdata[15:0] = rxev;
        end else if (hit(req.raddr, IST_IDX)) begin
            rsp.rdata[IRQ_W-1:0] = ist;
        end else if (hit(req.raddr, IMSK_IDX)) begin
            rsp.rdata[IRQ_W-1:0] = imsk_reg;
        end else begin
            rsp.rerr = 1'b1;
        end
        rsp.werr = !(hit(req.waddr, TXMSK_IDX) || hit(req.waddr, IST_IDX)
                     || hit(req.waddr, IMSK_IDX) || hit(req.waddr, TXEV_IDX)
                     || hit(req.waddr, RXEV_IDX));
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    for (genvar i = 0; i < EP_N; i++) begin : g_chk
        property p_txu_set;
            tx_underrun_set_i[i] |=> tx_underrun_flags_o[i] && txev[HI_LSB+i];
        endproperty
        a_txu_set: assert property (p_txu_set) else $error("underrun flag not set"); // RQ1

        property p_txu_clr;
            tx_status_rd_i[i] && !freeze_i && !tx_underrun_set_i[i] |=> !tx_underrun_flags_o[i];
        endproperty
        a_txu_clr: assert property (p_txu_clr) else $error("underrun flag not cleared"); // RQ2

        property p_txd_set;
            tx_done_set_i[i] |=> tx_done_flags_o[i] ##1 (tx_done_flags_o[i] || $past(tx_clr[i]));
        endproperty
        a_txd_set: assert property (p_txd_set) else $error("done flag not set"); // RQ3

        property p_txd_clr;
            tx_status_rd_i[i] && !freeze_i && !tx_done_set_i[i] |=> !tx_done_flags_o[i];
        endproperty
        a_txd_clr: assert property (p_txd_clr) else $error("done flag not cleared"); // RQ4

        property p_rxo_set;
            rx_overrun_set_i[i] |=> rx_overrun_flags_o[i] && ist[IRQ_RX_OVR];
        endproperty
        a_rxo_set: assert property (p_rxo_set) else $error("overrun flag not set"); // RQ6

        property p_rxc_set;
            $rose(rx_err_i[i]) || $rose(rx_last_i[i]) |=> rx_complete_flags_o[i];
        endproperty
        a_rxc_set: assert property (p_rxc_set) else $error("rx complete flag not set"); // RQ8

        property p_rxc_clr;
            rx_status_rd_i[i] && !freeze_i && !rxc_set[i] |=> !rx_complete_flags_o[i];
        endproperty
        a_rxc_clr: assert property (p_rxc_clr) else $error("rx complete flag not cleared"); // RQ9
    end

    property p_rxo_clr;
        rd_rxev && !freeze_i && rx_overrun_set_i == '0 |=> rx_overrun_flags_o == '0;
    endproperty
    a_rxo_clr: assert property (p_rxo_clr) else $error("overrun flags not cleared by read"); // RQ7

    property p_sum;
        txmsk_reg == '0 |=> !transmit_summary_event_o;
    endproperty
    a_sum: assert property (p_sum) else $error("masked event raised summary"); // RQ5

    property p_sum_on;
        (txev[6:0] & txmsk_reg) != '0 |=> transmit_summary_event_o;
    endproperty
    a_sum_on: assert property (p_sum_on) else $error("summary missing"); // RQ5

    property p_sum_off;
        (txev[6:0] & txmsk_reg) == '0 |=> !transmit_summary_event_o;
    endproperty
    a_sum_off: assert property (p_sum_off) else $error("summary without unmasked flag"); // RQ5

    property p_freeze;
        freeze_i && tx_underrun_set_i == '0 && rx_overrun_set_i == '0
            |=> tx_underrun_flags_o == $past(tx_underrun_flags_o)
                && rx_overrun_flags_o == $past(rx_overrun_flags_o);
    endproperty
    a_freeze: assert property (p_freeze) else $error("flag cleared during freeze"); // RQ10

    property p_ep0;
        ep0_rx_end_i && ep0_rx_err_i |=> ep0_discard_o && !ep0_accept_o
            ##1 (!ep0_discard_o || $past(ep0_rx_end_i && ep0_rx_err_i));
    endproperty
    a_ep0: assert property (p_ep0) else $error("errored packet not discarded"); // RQ11

    property p_ep0_ok;
        ep0_rx_end_i && !ep0_rx_err_i |=> ep0_accept_o && !ep0_discard_o;
    endproperty
    a_ep0_ok: assert property (p_ep0_ok) else $error("clean packet not accepted"); // RQ11

    property p_rsv;
        s_axi_rvalid_o |-> s_axi_rdata_o[31:7] == '0 && !s_axi_rdata_o[3];
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero"); // RQ13

    c_rxev_read: cover property (rd_rxev && rx_overrun_flags_o != '0);
    c_freeze_read: cover property (freeze_i && tx_status_rd_i != '0 && tx_underrun_flags_o != '0);
    c_irq: cover property ($rose(irq_o));
    c_ep0_discard: cover property (ep0_discard_o);
    c_sum_rise: cover property ($rose(transmit_summary_event_o));

endmodule

`default_nettype wire

// *** ueef_flag_bank.sv ***
`timescale 1ns/100ps
`default_nettype none

module ueef_flag_bank
    import ueef_pkg::*;
#(
    parameter int unsigned W = 3
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] set_i,
    input  wire logic [W-1:0] clr_i,
    output var  logic [W-1:0] flags_o
);

    logic [W-1:0] flags_reg;

    // Sticky flags, a set in the clearing cycle wins
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= (flags_reg & ~clr_i) | set_i;
        end
    end

    assign flags_o = flags_reg;

endmodule

`default_nettype wire

// *** ueef_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module ueef_host_model
    import ueef_pkg::*;
#(
    parameter int unsigned GAP = 1
) (
    input  wire logic            clk_i,
    output var  logic [EP_N-1:0] tx_underrun_set_o,
    output var  logic [EP_N-1:0] tx_done_set_o,
    output var  logic [EP_N-1:0] rx_overrun_set_o,
    output var  logic [EP_N-1:0] rx_err_o,
    output var  logic [EP_N-1:0] rx_last_o,
    output var  logic            ep0_end_o,
    output var  logic            ep0_err_o
);
    initial begin
        tx_underrun_set_o = '0;
        tx_done_set_o = '0;
        rx_overrun_set_o = '0;
        rx_err_o = '0;
        rx_last_o = '0;
        ep0_end_o = 1'b0;
        ep0_err_o = 1'b1;
    end

    // One event after an idle gap: 0 underrun, 1 done, 2 overrun, 3 rx error, 4 rx last
    task automatic ev(input int k, input logic [EP_N-1:0] m);
        repeat (GAP) @(posedge clk_i);
        case (k)
            0: tx_underrun_set_o <= m;
            1: tx_done_set_o <= m;
            2: rx_overrun_set_o <= m;
            3: rx_err_o <= m;
            default: rx_last_o <= m;
        endcase
        @(posedge clk_i);
        tx_underrun_set_o <= '0;
        tx_done_set_o <= '0;
        rx_overrun_set_o <= '0;
        rx_err_o <= '0;
        rx_last_o <= '0;
    endtask

    // Endpoint zero packet end, error qualifier inverted once released
    task automatic ep0(input logic err);
        repeat (GAP) @(posedge clk_i);
        ep0_end_o <= 1'b1;
        ep0_err_o <= err;
        @(posedge clk_i);
        ep0_end_o <= 1'b0;
        ep0_err_o <= ~err;
    endtask
endmodule

`default_nettype wire

// *** ueef_pkg.sv ***
package ueef_pkg;

    localparam int unsigned EP_N     = 3;
    localparam int unsigned ADDR_W   = 12;

    // Register indices; byte address is four times the index's low ten bits
    localparam logic [31:0] TXEV_IDX  = 32'h5000_1814;
    localparam logic [31:0] TXMSK_IDX = 32'h5000_1816;
    localparam logic [31:0] RXEV_IDX  = 32'h5000_1818;
    localparam logic [31:0] IST_IDX   = 32'h5000_1830;
    localparam logic [31:0] IMSK_IDX  = 32'h5000_1832;

    // Field positions in the event and mask registers
    localparam int unsigned HI_LSB = 4;
    localparam int unsigned LO_LSB = 0;

    // Interrupt status bit positions
    localparam int unsigned IRQ_W        = 3;
    localparam int unsigned IRQ_TX_SUM   = 0;
    localparam int unsigned IRQ_RX_OVR   = 1;
    localparam int unsigned IRQ_EP0_DISC = 2;

    // Reset values
    localparam logic [6:0]       TXMSK_RST = 7'h00;
    localparam logic [IRQ_W-1:0] IMSK_RST  = 3'h0;
    localparam logic [EP_N-1:0]  FLAG_RST  = 3'h0;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] waddr;
        logic [ADDR_W-1:0] raddr;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
    } ueef_reg_req_s;

    typedef struct packed {
        logic [31:0] rdata;
        logic        rerr;
        logic        werr;
    } ueef_reg_rsp_s;

endpackage

// *** usb_endpoint_event_flags_tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module usb_endpoint_event_flags_tb
    import ueef_pkg::*;
;
    localparam logic [11:0] A_TXEV = {TXEV_IDX[9:0], 2'b00};
    localparam logic [11:0] A_TXMSK = {TXMSK_IDX[9:0], 2'b00};
    localparam logic [11:0] A_RXEV = {RXEV_IDX[9:0], 2'b00};
    localparam logic [11:0] A_IST = {IST_IDX[9:0], 2'b00};
    localparam logic [11:0] A_IMSK = {IMSK_IDX[9:0], 2'b00};

    logic              clk = 1'b0, rst_n = 1'b0, freeze = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [31:0]       wdata = '0, rdata, m;
    logic [3:0]        wstrb = 4'hf;
    logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic              awready, wready, bvalid, arready, rvalid, summary, irq, disc, acc, e0end, e0err;
    logic [1:0]        bresp, rresp;
    logic [EP_N-1:0]   tx_rd = '0, rx_rd = '0, fu, fd, fo, fc, und, dn, ovr, rerr, rlast, b;
    logic [6:0]        v;
    logic [11:0]       f12;
    logic [33:0]       expq[$];
    int                failures = 0, num_checks = 0;

    always #12.5 clk = ~clk;

    ueef_core i_dut (
        .clk_i(clk), .rst_n_i(rst_n),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .freeze_i(freeze), .tx_underrun_set_i(und), .tx_done_set_i(dn), .tx_status_rd_i(tx_rd),
        .rx_overrun_set_i(ovr), .rx_err_i(rerr), .rx_last_i(rlast), .rx_status_rd_i(rx_rd),
        .ep0_rx_end_i(e0end), .ep0_rx_err_i(e0err), .ep0_discard_o(disc), .ep0_accept_o(acc),
        .transmit_summary_event_o(summary), .tx_underrun_flags_o(fu), .tx_done_flags_o(fd),
        .rx_overrun_flags_o(fo), .rx_complete_flags_o(fc), .irq_o(irq)
    );

    ueef_host_model #(.GAP(1)) i_host (
        .clk_i(clk), .tx_underrun_set_o(und), .tx_done_set_o(dn), .rx_overrun_set_o(ovr),
        .rx_err_o(rerr), .rx_last_o(rlast), .ep0_end_o(e0end), .ep0_err_o(e0err)
    );

    task automatic check(input string n, input logic [33:0] e, input logic [33:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cf(input logic [11:0] e);
        check("flags", 34'(e), 34'({fu, fd, fo, fc}));
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw, w, bh;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        bh = 1'b0;
        while (!bh) begin
            @(negedge clk);
            aw = awvalid && awready;
            w = wvalid && wready;
            bh = bvalid && bready;
            if (bh) check("bresp", 34'(r), 34'(bresp));
            @(posedge clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (bh) bready <= 1'b0;
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ar, rh;
        expq.push_back({r, d});
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        rh = 1'b0;
        while (!rh) begin
            @(negedge clk);
            ar = arvalid && arready;
            rh = rvalid && rready;
            @(posedge clk);
            if (ar) arvalid <= 1'b0;
            if (rh) rready <= 1'b0;
        end
    endtask

    // Read result monitor
    always @(negedge clk) begin
        if (rvalid === 1'b1 && rready === 1'b1 && expq.size() > 0) check("rdata", expq.pop_front(), {rresp, rdata});
    end

    // Status register read strobe, optionally under freeze
    task automatic srd(input logic rx, input logic [2:0] s, input logic f);
        @(posedge clk);
        freeze <= f;
        if (rx) rx_rd <= s;
        else tx_rd <= s;
        @(posedge clk);
        tx_rd <= '0;
        rx_rd <= '0;
        freeze <= 1'b0;
        #1;
    endtask

    task automatic sum_chk(input logic x);
        repeat (2) @(posedge clk);
        #1;
        check("summary", 34'(x), 34'(summary));
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #(25 * 20000);
        failures++;
        wrap_up();
    end

    initial begin
        void'($urandom(32'h65a33f71));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        check("outs", 34'h0, 34'({summary, irq, disc, acc, fu, fd, fo, fc}));
        rd(A_TXEV, 32'h0, RESP_OKAY);
        rd(A_TXMSK, 32'(TXMSK_RST), RESP_OKAY);
        rd(A_RXEV, 32'h0, RESP_OKAY);
        rd(A_IMSK, 32'(IMSK_RST), RESP_OKAY);
        rd(12'h004, 32'h0, RESP_SLVERR);
        wr(12'h3fc, 32'h1, RESP_SLVERR);
        m = $urandom;
        wr(A_TXMSK, m, RESP_OKAY);
        rd(A_TXMSK, m & 32'h77, RESP_OKAY);
        wr(A_TXMSK, 32'h0, RESP_OKAY);
        wr(A_TXEV, 32'hffff, RESP_OKAY);
        rd(A_TXEV, 32'h0, RESP_OKAY);
        for (int k = 0; k < 2; k++) begin
            for (int e = 0; e < EP_N; e++) begin
                b = 3'(1 << e);
                v = (k == 0) ? {b, 4'h0} : {4'h0, b};
                f12 = (k == 0) ? {b, 9'h0} : {3'h0, b, 6'h0};
                i_host.ev(k, b);
                #1;
                cf(f12);
                rd(A_TXEV, 32'(v), RESP_OKAY);
                rd(A_TXEV, 32'(v), RESP_OKAY);
                wr(A_TXMSK, 32'(~v), RESP_OKAY);
                sum_chk(1'b0);
                wr(A_TXMSK, 32'(v), RESP_OKAY);
                sum_chk(1'b1);
                srd(1'b0, b, 1'b1);
                cf(f12);
                srd(1'b0, b, 1'b0);
                cf(12'h0);
                wr(A_TXMSK, 32'h0, RESP_OKAY);
            end
        end
        b = 3'($urandom_range(1, 7));
        i_host.ev(2, b);
        #1;
        cf({6'h0, b, 3'h0});
        @(posedge clk);
        freeze <= 1'b1;
        rd(A_RXEV, 32'({b, 4'h0}), RESP_OKAY);
        rd(A_RXEV, 32'({b, 4'h0}), RESP_OKAY);
        freeze <= 1'b0;
        rd(A_RXEV, 32'({b, 4'h0}), RESP_OKAY);
        rd(A_RXEV, 32'h0, RESP_OKAY);
        for (int e = 0; e < EP_N; e++) begin
            b = 3'(1 << e);
            i_host.ev(3 + int'($urandom_range(0, 1)), b);
            #1;
            cf({9'h0, b});
            rd(A_RXEV, 32'(b), RESP_OKAY);
            srd(1'b1, b, 1'b1);
            cf({9'h0, b});
            srd(1'b1, b, 1'b0);
            cf(12'h0);
        end
        for (int i = 1; i >= 0; i--) begin
            i_host.ep0(i[0]);
            #1;
            check("ep0", 34'({i[0], ~i[0]}), 34'({disc, acc}));
            @(posedge clk);
            #1;
            check("ep0 end", 34'h0, 34'({disc, acc}));
        end
        wr(A_IST, 32'h7, RESP_OKAY);
        rd(A_IST, 32'h0, RESP_OKAY);
        i_host.ev(2, 3'h1);
        repeat (3) @(posedge clk);
        #1;
        check("irq masked", 34'h0, 34'(irq));
        rd(A_IST, 32'h2, RESP_OKAY);
        wr(A_IMSK, 32'h2, RESP_OKAY);
        repeat (2) @(posedge clk);
        #1;
        check("irq", 34'h1, 34'(irq));
        wr(A_IST, 32'h2, RESP_OKAY);
        repeat (2) @(posedge clk);
        #1;
        check("irq clear", 34'h0, 34'(irq));
        rd(A_IST, 32'h0, RESP_OKAY);
        repeat (4) @(posedge clk);
        wrap_up();
    end
endmodule

`default_nettype wire
